// [design/bias_seq_map.vh]
`ifndef BIAS_SEQ_MAP_VH
`define BIAS_SEQ_MAP_VH
// Sequencer states
`define ST_OFF        3'h0
`define ST_STARTUP    3'h1
`define ST_SOFTSTART  3'h2
`define ST_RUN        3'h3
`define ST_FAULT      3'h4
// Startup timeout in ns, and its count at 10 ns per cycle
`define CLK_PERIOD_NS 10
`define STARTUP_TIMEOUT_NS 700000
`define STARTUP_TIMEOUT_CYC (`STARTUP_TIMEOUT_NS / `CLK_PERIOD_NS)
// Status and mask bit positions
`define EV_UVLO_REL   0
`define EV_REF_LOSS   1
`define EV_FAULT      2
`define EV_TIMEOUT    3
`define EV_WIDTH      4
// Register offsets
`define ADDR_STATUS   4'h0
`define ADDR_MASK     4'h1
`define ADDR_STATE    4'h2
`define ADDR_CONFIG   4'h3
// Reset values
`define MASK_RST      4'h0
`define CONFIG_RST    1'h0
`endif

// [design/bias_startup_sequencer.v]
// Operation
// - Reference bias stays off until lockout releases at supply turn-on.
// - Reference power-good loss stops switching, drops reference, forces restart.
// - Lockout releases at turn-on level, reasserts at turn-off level.
// - In startup, both power-path switches tie sense and bias pins to supply.
// - Discriminator and switching enabled only after supply startup completes.
// - At turn-on, open startup switches then connect gate-bias regulator.
// - Startup limit high below short-detect level, low above it.
// - Tuning threshold high when strap high, low when strap low.
// - Gate-bias pin open or shorted during startup enters fault.
// - Gate-bias overvoltage in run state enters fault.
// - Startup includes timeout timer that may lengthen soft start; here the timer only ends soft start, moving to run at TIMEOUT_CYC.
//
// The implementer's own choices: the register offsets and the strobed register port.
`include "bias_seq_map.vh"
module bias_startup_sequencer #(
    parameter TIMEOUT_CYC = `STARTUP_TIMEOUT_CYC
) (
    input  wire       CLK,            // 100 MHz clock
    input  wire       RST_B,          // Async reset, active low
    input  wire       SUPPLY_ON,      // Supply above turn-on level
    input  wire       SUPPLY_OFF,     // Supply below turn-off level
    input  wire       SUPPLY_SHORT_OK,// Supply above short-detect level
    input  wire       REF_GOOD,       // Reference rail above power-good
    input  wire       GATE_RAIL_FAULT,// Gate-bias pin open or shorted
    input  wire       GATE_RAIL_OV,   // Gate-bias rail overvoltage
    input  wire       SOFTSTART_DONE, // Output soft start finished
    input  wire       TUNE_STRAP,     // Tuning threshold strap
    input  wire [3:0] ADDR,           // Register address
    input  wire [7:0] WDATA,          // Register write data
    input  wire       WR,             // Write strobe
    input  wire       RD,             // Read strobe
    output reg  [7:0] RDATA,          // Read data, one cycle later
    output wire       IRQ,            // Level interrupt
    output reg        UVLO,           // Lockout active
    output reg        SENSE_PATH_ON,  // Sense pin tied to supply
    output reg        BIAS_PATH_ON,   // Bias pin tied to supply
    output reg        GATE_REG_ON,    // Gate-bias regulator connected
    output reg        LIMIT_HIGH,     // High startup limit resistance
    output reg        REF_EN,         // Reference bias enable
    output reg        SWITCH_EN,      // Switching and discriminator enable
    output reg        FAULT,          // Fault indication
    output reg        TUNE_HIGH,      // High tuning threshold selected
    output reg        TIMEOUT         // Startup timeout expired
);
    reg         rst_s1_reg;
    reg         rst_s2_reg;
    wire        rst_b = rst_s2_reg;
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [16:0] timer_reg;
    reg  [3:0]  status_reg;
    reg  [3:0]  mask_reg;
    reg         hold_reg;
    reg         strap_reg;
    wire [3:0]  ev;
    // Decoded next and current state, shared by the output registers
    wire        nx_lock;
    wire        nx_active;
    wire        nx_fault;
    wire        cur_soft;
    wire        tmo_hit;

    // Lockout covers the idle and startup states; fault keeps its own flag
    assign nx_lock   = (state_next == `ST_STARTUP) || (state_next == `ST_OFF);
    // Reference and regulator live only in soft start and run
    assign nx_active = (state_next == `ST_SOFTSTART) || (state_next == `ST_RUN);
    assign nx_fault  = (state_next == `ST_FAULT);
    // Timer end point, seen only while soft start lasts
    assign cur_soft  = (state_reg == `ST_SOFTSTART);
    assign tmo_hit   = (timer_reg == TIMEOUT_CYC[16:0]);

    // Reset release synchroniser
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    // Next state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            `ST_OFF: begin
                state_next = `ST_STARTUP;
            end
            `ST_STARTUP: begin
                if (GATE_RAIL_FAULT)
                    state_next = `ST_FAULT;
                else if (SUPPLY_ON)
                    state_next = `ST_SOFTSTART;
            end
            `ST_SOFTSTART: begin
                if (SUPPLY_OFF)
                    state_next = `ST_STARTUP;
                else if (!REF_GOOD)
                    state_next = `ST_STARTUP;
                else if (SOFTSTART_DONE || timer_reg == TIMEOUT_CYC[16:0])
                    state_next = `ST_RUN;
            end
            `ST_RUN: begin
                if (GATE_RAIL_OV)
                    state_next = `ST_FAULT;
                else if (SUPPLY_OFF)
                    state_next = `ST_STARTUP;
                else if (!REF_GOOD)
                    state_next = `ST_STARTUP;
            end
            `ST_FAULT: begin
                if (SUPPLY_OFF)
                    state_next = `ST_STARTUP;
            end
            default: state_next = `ST_OFF;
        endcase
    end

    // State, timer and strap capture
    always @(posedge CLK or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= `ST_OFF;
            timer_reg <= 17'h0;
            hold_reg  <= 1'b0;
            strap_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            hold_reg  <= 1'b1;
            // Strap caught once after reset release
            if (!hold_reg)
                strap_reg <= TUNE_STRAP;
            if (state_reg != `ST_SOFTSTART)
                timer_reg <= 17'h0;
            else if (timer_reg != TIMEOUT_CYC[16:0])
                timer_reg <= timer_reg + 17'h1;
        end
    end

    // Registered control outputs, one process per output group.
    // UVLO, the paths, REF_EN and FAULT look at the next state so they change with the state
    // register, not one clock behind it.

    always @(posedge CLK or negedge rst_b) begin
        if (!rst_b)
            UVLO <= 1'b1;
        else
            UVLO <= nx_lock || nx_fault;
    end

    // startup paths closed
    // Paths stay open in fault so a shorted rail is not fed from supply
    always @(posedge CLK or negedge rst_b) begin
        if (!rst_b) begin
            SENSE_PATH_ON <= 1'b1;
            BIAS_PATH_ON  <= 1'b1;
        end else begin
            SENSE_PATH_ON <= nx_lock;
            BIAS_PATH_ON  <= nx_lock;
        end
    end

    // regulator after paths open
    // Waits on the path register so regulator and paths never overlap
    always @(posedge CLK or negedge rst_b) begin
        if (!rst_b)
            GATE_REG_ON <= 1'b0;
        else
            GATE_REG_ON <= nx_active && !SENSE_PATH_ON;
    end

    // limit resistance select
    // Follows the short comparator; high limit protects a shorted supply
    always @(posedge CLK or negedge rst_b) begin
        if (!rst_b)
            LIMIT_HIGH <= 1'b1;
        else
            LIMIT_HIGH <= !SUPPLY_SHORT_OK;
    end

    // reference after lockout release
    // Reference good is not blanked: the comparator must settle in a cycle
    always @(posedge CLK or negedge rst_b) begin
        if (!rst_b)
            REF_EN <= 1'b0;
        else
            REF_EN <= nx_active;
    end

    // switching after startup
    // Same gating as the regulator, so the discriminator sees a biased rail
    always @(posedge CLK or negedge rst_b) begin
        if (!rst_b)
            SWITCH_EN <= 1'b0;
        else
            SWITCH_EN <= nx_active && !SENSE_PATH_ON;
    end

    // fault flag
    // Held for as long as the state machine stays in fault
    always @(posedge CLK or negedge rst_b) begin
        if (!rst_b)
            FAULT <= 1'b0;
        else
            FAULT <= nx_fault;
    end

    // tuning threshold
    // Pin value on the first cycle, the captured strap afterwards
    always @(posedge CLK or negedge rst_b) begin
        if (!rst_b)
            TUNE_HIGH <= 1'b0;
        else
            TUNE_HIGH <= hold_reg ? strap_reg : TUNE_STRAP;
    end

    // timeout pulse
    // One cycle wide, as the state leaves soft start on the same edge
    always @(posedge CLK or negedge rst_b) begin
        if (!rst_b)
            TIMEOUT <= 1'b0;
        else
            TIMEOUT <= cur_soft && tmo_hit;
    end

    assign ev[`EV_UVLO_REL] = (state_reg == `ST_STARTUP) && (state_next == `ST_SOFTSTART);
    assign ev[`EV_REF_LOSS] = ((state_reg == `ST_SOFTSTART) || (state_reg == `ST_RUN))
                              && !REF_GOOD;
    assign ev[`EV_FAULT]    = (state_reg != `ST_FAULT) && (state_next == `ST_FAULT);
    assign ev[`EV_TIMEOUT]  = (state_reg == `ST_SOFTSTART)
                              && (timer_reg == TIMEOUT_CYC[16:0]) && !TIMEOUT;

    // Sticky status, write one to clear, set wins
    genvar i;
    generate
        for (i = 0; i < `EV_WIDTH; i = i + 1) begin : g_stat
            always @(posedge CLK or negedge rst_b) begin
                if (!rst_b)
                    status_reg[i] <= 1'b0;
                else if (ev[i])
                    status_reg[i] <= 1'b1;
                else if (WR && ADDR == `ADDR_STATUS && WDATA[i])
                    status_reg[i] <= 1'b0;
            end
        end
    endgenerate

    // Register map seen by software:
    //   0 status, write one to clear
    //   1 interrupt mask, same layout as status
    //   2 state snapshot with the main control levels
    //   3 captured tuning strap
    // Unmapped addresses read zero and ignore writes.
    // Mask write and read data
    always @(posedge CLK or negedge rst_b) begin
        if (!rst_b) begin
            mask_reg <= `MASK_RST;
            RDATA    <= 8'h00;
        end else begin
            if (WR && ADDR == `ADDR_MASK)
                mask_reg <= WDATA[3:0];
            RDATA <= 8'h00;
            if (RD) begin
                case (ADDR)
                    `ADDR_STATUS: RDATA <= {4'h0, status_reg};
                    `ADDR_MASK:   RDATA <= {4'h0, mask_reg};
                    `ADDR_STATE:  RDATA <= {FAULT, SWITCH_EN, REF_EN, UVLO, 1'b0, state_reg};
                    `ADDR_CONFIG: RDATA <= {7'h00, strap_reg};
                    default:      RDATA <= 8'h00;
                endcase
            end
        end
    end

    // Interrupt level
    assign IRQ = |(status_reg & mask_reg);

endmodule // bias_startup_sequencer

// [verif/bias_seq_sva.sv]
module bias_seq_sva (
    input wire logic CLK, RST_B, SUPPLY_OFF, SUPPLY_SHORT_OK, REF_GOOD, TUNE_STRAP,
    input wire logic UVLO, SENSE_PATH_ON, BIAS_PATH_ON, GATE_REG_ON, LIMIT_HIGH,
    input wire logic REF_EN, SWITCH_EN, FAULT, TUNE_HIGH
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    // Sequencing relations
    ref_lock_a: assert property (UVLO |-> !REF_EN)
        else $error("reference on in lockout");
    path_hold_a: assert property (UVLO && !FAULT |-> SENSE_PATH_ON && BIAS_PATH_ON)
        else $error("paths open in lockout");
    sw_after_a: assert property (SWITCH_EN |-> !UVLO)
        else $error("switching in lockout");
    reg_excl_a: assert property (GATE_REG_ON |-> !SENSE_PATH_ON && !BIAS_PATH_ON)
        else $error("regulator with paths closed");
    fault_hold_a: assert property (FAULT |-> !SWITCH_EN)
        else $error("switching in fault");
    ref_loss_a: assert property (SWITCH_EN && !REF_GOOD |-> ##[1:2] !SWITCH_EN && !REF_EN)
        else $error("no stop on reference loss");
    uvlo_again_a: assert property (SWITCH_EN && SUPPLY_OFF |-> ##[1:3] UVLO && !GATE_REG_ON)
        else $error("no lockout on supply loss");
    limit_low_a: assert property ((UVLO && !FAULT && SUPPLY_SHORT_OK)[*6] |-> !LIMIT_HIGH)
        else $error("limit not lowered");
    limit_high_a: assert property ((UVLO && !FAULT && !SUPPLY_SHORT_OK)[*6] |-> LIMIT_HIGH)
        else $error("limit not raised");
    tune_sel_a: assert property ($rose(SWITCH_EN) |-> TUNE_HIGH == TUNE_STRAP)
        else $error("tuning level wrong");
    // Main scenarios
    cover property ($rose(SWITCH_EN));
    cover property ($rose(FAULT));
    cover property (SWITCH_EN ##1 UVLO);
endmodule // bias_seq_sva
bind bias_startup_sequencer bias_seq_sva i_sva (.CLK(CLK), .RST_B(RST_B),
    .SUPPLY_OFF(SUPPLY_OFF), .SUPPLY_SHORT_OK(SUPPLY_SHORT_OK), .REF_GOOD(REF_GOOD),
    .TUNE_STRAP(TUNE_STRAP), .UVLO(UVLO), .SENSE_PATH_ON(SENSE_PATH_ON),
    .BIAS_PATH_ON(BIAS_PATH_ON), .GATE_REG_ON(GATE_REG_ON), .LIMIT_HIGH(LIMIT_HIGH),
    .REF_EN(REF_EN), .SWITCH_EN(SWITCH_EN), .FAULT(FAULT), .TUNE_HIGH(TUNE_HIGH));

// [verif/bias_front_model.sv]
module bias_front_model (
    input  logic ref_en,   // Reference enable
    input  logic shut,     // Shutdown switch drive
    input  int   vdd,      // Supply in 0.1 V steps
    output logic sup_on,   // At turn-on level
    output logic sup_off,  // At turn-off level
    output logic short_ok, // Above short-detect
    output logic ref_good  // Reference power-good
);
    timeunit 1ns;
    timeprecision 1ps;
    // hysteresis comparators
    assign sup_on = vdd >= 170;
    assign sup_off = vdd <= 106;
    assign short_ok = vdd > 18;
    assign ref_good = ref_en && !shut;
endmodule // bias_front_model

// [verif/bias_startup_sequencer_tb_top.sv]
module bias_startup_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0, RST_B = 1'b0, shut = 1'b0, strap = 1'b0, flt_in = 1'b0, ov = 1'b0;
    logic done = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic s_on, s_off, s_ok, rg, irq, uvlo, sns, bia, greg, lim, ren, swe, flt, tune, tmo;
    int vdd = 0, num_errors = 0, cmp_count = 0, cyc_n = 0;
    always #5 CLK = ~CLK;
    bias_front_model i_fe (.ref_en(ren), .shut(shut), .vdd(vdd), .sup_on(s_on),
        .sup_off(s_off), .short_ok(s_ok), .ref_good(rg));
    bias_startup_sequencer #(.TIMEOUT_CYC(20)) i_dut (.CLK(CLK), .RST_B(RST_B),
        .SUPPLY_ON(s_on), .SUPPLY_OFF(s_off), .SUPPLY_SHORT_OK(s_ok), .REF_GOOD(rg),
        .GATE_RAIL_FAULT(flt_in), .GATE_RAIL_OV(ov), .SOFTSTART_DONE(done),
        .TUNE_STRAP(strap), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .IRQ(irq), .UVLO(uvlo), .SENSE_PATH_ON(sns), .BIAS_PATH_ON(bia),
        .GATE_REG_ON(greg), .LIMIT_HIGH(lim), .REF_EN(ren), .SWITCH_EN(swe),
        .FAULT(flt), .TUNE_HIGH(tune), .TIMEOUT(tmo));
    task automatic close_out();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic ck(input string n, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    // One bus cycle; read data checkable on return
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge CLK);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask
    // Sequencer outputs packed: run or lockout pattern
    function automatic logic [7:0] exp_st(input bit run);
        return run ? 8'h0e : 8'h70;
    endfunction
    function automatic logic [7:0] st();
        return {1'b0, uvlo, sns, bia, greg, ren, swe, flt};
    endfunction
    always @(posedge CLK) begin
        cyc_n++;
        if (cyc_n == 2000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        void'($urandom(32'hcf6e));
        strap <= 1'($urandom_range(1, 0));
        cy(2);
        RST_B <= 1'b1;
        cy(4);
        ck("lock", exp_st(0), st());
        vdd <= $urandom_range(18, 0);
        cy(8);
        ck("lim_hi", 8'h01, {7'h0, lim});
        vdd <= $urandom_range(169, 107);
        cy(8);
        ck("lim_lo", 8'h00, {7'h0, lim});
        ck("below_on", exp_st(0), st());
        vdd <= 170 + $urandom_range(30, 0);
        cy(6);
        ck("run", exp_st(1), st());
        ck("tune", {7'h0, strap}, {7'h0, tune});
        ck("tmo_early", 8'h00, {7'h0, tmo});
        cy(16);
        ck("tmo", 8'h01, {7'h0, tmo});
        bus(0, 4'h0, 8'h00);
        ck("status", 8'h09, rdata);
        bus(0, 4'h2, 8'h00);
        ck("state", 8'h63, rdata);
        bus(0, 4'h3, 8'h00);
        ck("config", {7'h0, strap}, rdata);
        bus(1, 4'hf, 8'hff);
        bus(0, 4'hf, 8'h00);
        ck("unmapped", 8'h00, rdata);
        bus(1, 4'h1, 8'h08);
        ck("irq_on", 8'h01, {7'h0, irq});
        bus(1, 4'h0, 8'h08);
        ck("irq_off", 8'h00, {7'h0, irq});
        bus(0, 4'h0, 8'h00);
        ck("w1c", 8'h01, rdata);
        bus(1, 4'h1, 8'h0f);
        bus(1, 4'h0, 8'h01);
        ck("irq_idle", 8'h00, {7'h0, irq});
        vdd <= 120;
        cy(4);
        ck("hyst", exp_st(1), st());
        shut <= 1'b1;
        cy(4);
        ck("ref_loss", exp_st(0), st());
        ck("irq_ref", 8'h01, {7'h0, irq});
        shut <= 1'b0;
        done <= 1'b1;
        vdd <= 175;
        cy(6);
        ov <= 1'b1;
        cy(4);
        ck("ov_fault", 8'h01, {6'h0, swe, flt});
        ov <= 1'b0;
        cy(4);
        ck("fault_hold", 8'h01, {6'h0, swe, flt});
        vdd <= 100;
        cy(4);
        ck("fault_exit", 8'h00, {7'h0, flt});
        vdd <= 120;
        flt_in <= 1'b1;
        cy(4);
        ck("rail_fault", 8'h01, {7'h0, flt});
        flt_in <= 1'b0;
        vdd <= 100;
        cy(4);
        vdd <= 180;
        cy(8);
        vdd <= 100;
        cy(4);
        ck("relock", exp_st(0), st());
        bus(1, 4'h0, 8'h0f);
        bus(0, 4'h0, 8'h00);
        ck("clear", 8'h00, rdata);
        close_out();
    end
endmodule // bias_startup_sequencer_tb_top
